/* sfsp_defs.vh */
// sfsp_defs.vh: register offsets, field positions and widths for the
// supply fault and status plane. assumes an 8-bit register address.
`ifndef SFSP_DEFS_VH
`define SFSP_DEFS_VH

// register offsets
`define SFSP_ADDR_FAULT_LO 8'hE0
`define SFSP_ADDR_FAULT_HI 8'hE1
`define SFSP_ADDR_OV_LO 8'hE2
`define SFSP_ADDR_OV_HI 8'hE3
`define SFSP_ADDR_UV_LO 8'hE4
`define SFSP_ADDR_UV_HI 8'hE5
`define SFSP_ADDR_LIM_LO 8'hE6
`define SFSP_ADDR_LIM_HI 8'hE7
`define SFSP_ADDR_DIG 8'hE8

// widths
`define SFSP_NSENSE 4
`define SFSP_NDUAL 5
`define SFSP_NAUX 3
`define SFSP_NCH 10
`define SFSP_NLIM 13

// fault plane bit positions in the 10-bit plane (lo byte then hi byte)
`define SFSP_FP_SENSE_LSB 0
`define SFSP_FP_HIGH 4
`define SFSP_FP_DUAL_LSB 5

// reset values
`define SFSP_FAULT_RST 10'h000
`define SFSP_RDATA_RST 8'h00

`endif

/* sfsp_fault_latch.v */
// sfsp_fault_latch.v: sticky fault plane capture.
// assumes fault indications are already resolved per channel and synchronous.
`timescale 1ns/1ps
`default_nettype none
`include "sfsp_defs.vh"

module sfsp_fault_latch (
  input wire ref_clk,
  input wire rst_b,
  input wire latch_en,
  input wire [`SFSP_NCH-1:0] fault_in,
  output reg [`SFSP_NCH-1:0] fault_plane_r
);

  wire [`SFSP_NCH-1:0] fault_plane_nxt;

  // sticky: no clear exists, so only reset empties the plane
  assign fault_plane_nxt = fault_plane_r | (latch_en ? fault_in : {`SFSP_NCH{1'b0}});

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_plane_r <= `SFSP_FAULT_RST;
    end else begin
      fault_plane_r <= fault_plane_nxt;
    end
  end

endmodule // sfsp_fault_latch

`default_nettype wire

/* sfsp_warn_or.v */
// sfsp_warn_or.v: wide OR that forms the sequencing engine warning.
// assumes limit and detector flags are synchronous levels.
`timescale 1ns/1ps
`default_nettype none
`include "sfsp_defs.vh"

module sfsp_warn_or (
  input wire ref_clk,
  input wire rst_b,
  input wire [`SFSP_NLIM-1:0] limit_flags,
  input wire [`SFSP_NSENSE:0] sec_ov,
  input wire [`SFSP_NSENSE:0] sec_uv,
  input wire sec_en,
  output reg warning_r
);

  wire warning_nxt;

  // secondary detectors only count when they are active
  assign warning_nxt = (|limit_flags) | (sec_en & ((|sec_ov) | (|sec_uv)));

  // registered so the engine sees a clean level
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      warning_r <= 1'b0;
    end else begin
      warning_r <= warning_nxt;
    end
  end

endmodule // sfsp_warn_or

`default_nettype wire

/* sfsp_status_plane.v */
// sfsp_status_plane.v: fault plane and live status registers of a supply
// sequencer, read through a simple synchronous register port.
// assumes all inputs are synchronous to ref_clk; the serial bus front end
// lives outside and presents address, read and write strobes.
`timescale 1ns/1ps
`default_nettype none
`include "sfsp_defs.vh"

// Contract
// - warning to the engine is OR of all limit and secondary detector outputs
// - secondary detectors on sense and high inputs work only in digital input mode; the warning counts all of them once any dual pin is digital
// - fault plane reports window faults, logic deassertion and limit violations
// - each fault bit is one function; one means a fault happened; dual bits of a pin in digital mode hold its logic level instead
// - dual-use pin in digital mode captures its true logic level
// - faults latch only while the active state's latch enable is one
// - over, under, limit and digital status registers are live, never latched
// - fault register low: dual 3..1, high-range, sense 4..1
// - fault register high: dual 5 in bit 1, dual 4 in bit 0
// - overvoltage low: dual 3..1 or warning, high-range, sense 4..1
// - overvoltage high: dual 5 or high warning, dual 4 or sense 4 warning
// - undervoltage low: dual 3..1 or warning, high-range, sense 4..1
// - undervoltage high: dual 5 or high warning, dual 4 or sense 4 warning
// - limit low: sense 1..4, high-range, dual 1..3 with limit sense one
// - limit high: dual 4, dual 5, three auxiliary or temperature channels
// - digital status: conditioned logic state of dual inputs 5..1 in bits 4..0
module sfsp_status_plane (
  input wire ref_clk,
  input wire rst_b,
  // register port
  input wire [7:0] reg_addr,
  input wire reg_rd,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata_r,
  output wire reg_hit,
  // sequencer side
  input wire state_fault_latch_en,
  output wire warning,
  // per-input configuration: 1 = dual-use input acts as digital input
  input wire [`SFSP_NDUAL-1:0] dual_is_digital,
  // supply_sense_input_1..4 and high_range_input window comparators
  input wire [`SFSP_NSENSE-1:0] sense_ov,
  input wire [`SFSP_NSENSE-1:0] sense_uv,
  input wire high_ov,
  input wire high_uv,
  // secondary detectors on sense 1..4 and high-range (bit 4)
  input wire [`SFSP_NSENSE:0] sec_ov,
  input wire [`SFSP_NSENSE:0] sec_uv,
  // dual_use_input_1..5 detectors
  input wire [`SFSP_NDUAL-1:0] dual_ov,
  input wire [`SFSP_NDUAL-1:0] dual_uv,
  // conditioned logic level of dual_use_input_1..5
  input wire [`SFSP_NDUAL-1:0] dual_logic,
  // adc limit comparisons: sense 1..4, high, dual 1..5, aux 1..3
  input wire [`SFSP_NSENSE-1:0] lim_sense,
  input wire lim_high,
  input wire [`SFSP_NDUAL-1:0] lim_dual,
  input wire [`SFSP_NAUX-1:0] lim_aux,
  // monitored logic input deassertion per dual pin, used in fault mode
  input wire [`SFSP_NDUAL-1:0] dual_deasserted,
  output wire [`SFSP_NCH-1:0] fault_plane
);

  // any secondary detector counts only when some dual pin is digital
  wire sec_en;
  // sec detectors enabled per dual pin: dual k pairs with sense k, dual 5 with high
  wire [`SFSP_NDUAL-1:0] sec_gate;
  wire [`SFSP_NDUAL-1:0] dual_ov_view;
  wire [`SFSP_NDUAL-1:0] dual_uv_view;
  wire [`SFSP_NDUAL-1:0] dual_fault;
  wire [`SFSP_NSENSE-1:0] sense_fault;
  wire high_fault;
  wire [`SFSP_NCH-1:0] fault_in;
  wire [`SFSP_NLIM-1:0] limit_flags;
  reg [7:0] rdata_nxt;

  // decode of the nine status addresses, used only for the hit flag; the read mux decodes the address itself
  function is_mapped;
    input [7:0] a;
    begin
      is_mapped = (a >= `SFSP_ADDR_FAULT_LO) && (a <= `SFSP_ADDR_DIG);
    end
  endfunction

  assign sec_en = |dual_is_digital;
  assign sec_gate = dual_is_digital;

  // a dual pin in detector mode shows its own detector, otherwise the
  // secondary warning of its partner sense or high-range input
  assign dual_ov_view = (dual_ov & ~dual_is_digital) | (sec_ov & sec_gate);
  assign dual_uv_view = (dual_uv & ~dual_is_digital) | (sec_uv & sec_gate);

  // fault causes: window excursion, logic deassertion, limit violation
  assign sense_fault = sense_ov | sense_uv | lim_sense;
  assign high_fault = high_ov | high_uv | lim_high;
  // digital mode records the true pin level, not a fault
  assign dual_fault = (dual_logic & dual_is_digital) |
                      ((dual_ov | dual_uv | dual_deasserted | lim_dual) & ~dual_is_digital);

  // plane layout: sense 1..4 at 3:0, high at 4, dual 1..5 at 9:5
  assign fault_in = {dual_fault, high_fault, sense_fault};

  sfsp_fault_latch u_latch (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .latch_en(state_fault_latch_en),
    .fault_in(fault_in),
    .fault_plane_r(fault_plane)
  );

  // limit flags in register order: sense, high, dual, aux
  assign limit_flags = {lim_aux, lim_dual, lim_high, lim_sense};

  sfsp_warn_or u_warn (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .limit_flags(limit_flags),
    .sec_ov(sec_ov),
    .sec_uv(sec_uv),
    .sec_en(sec_en),
    .warning_r(warning)
  );

  assign reg_hit = (reg_rd | reg_wr) & is_mapped(reg_addr);

  // read mux; status views are live inputs, never stored
  always @* begin
    rdata_nxt = `SFSP_RDATA_RST;
    case (reg_addr)
      `SFSP_ADDR_FAULT_LO: rdata_nxt = fault_plane[7:0];
      `SFSP_ADDR_FAULT_HI: rdata_nxt = {6'b00_0000, fault_plane[9:8]};
      `SFSP_ADDR_OV_LO: rdata_nxt = {dual_ov_view[2:0], high_ov, sense_ov};
      `SFSP_ADDR_OV_HI: rdata_nxt = {6'b00_0000, dual_ov_view[4:3]};
      `SFSP_ADDR_UV_LO: rdata_nxt = {dual_uv_view[2:0], high_uv, sense_uv};
      `SFSP_ADDR_UV_HI: rdata_nxt = {6'b00_0000, dual_uv_view[4:3]};
      `SFSP_ADDR_LIM_LO: rdata_nxt = {lim_dual[2:0], lim_high, lim_sense};
      `SFSP_ADDR_LIM_HI: rdata_nxt = {3'b000, lim_aux, lim_dual[4:3]};
      `SFSP_ADDR_DIG: rdata_nxt = {3'b000, dual_logic};
      default: rdata_nxt = `SFSP_RDATA_RST;
    endcase
  end

  // read data registered on a read strobe; writes change no state and only
  // raise reg_hit, since every register here is read-only
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_r <= `SFSP_RDATA_RST;
    end else if (reg_rd) begin
      reg_rdata_r <= rdata_nxt;
    end
  end

endmodule // sfsp_status_plane

`default_nettype wire

/* sfsp_chk_sva.sv */
// sfsp_chk_sva.sv: port checks of the status plane.
// assumes the plane top and its defines header.
`timescale 1ns/1ps
`default_nettype none
`include "sfsp_defs.vh"
module sfsp_chk (
  input wire ref_clk,
  input wire rst_b,
  input wire [7:0] reg_addr,
  input wire reg_rd,
  input wire reg_wr,
  input wire [7:0] reg_rdata_r,
  input wire reg_hit,
  input wire state_fault_latch_en,
  input wire warning,
  input wire [`SFSP_NSENSE-1:0] sense_ov,
  input wire [`SFSP_NDUAL-1:0] dual_logic,
  input wire [`SFSP_NAUX-1:0] lim_aux,
  input wire [`SFSP_NCH-1:0] fault_plane
);
  // one domain; reset masks every check
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_fault_sticky: assert property ((fault_plane & $past(fault_plane)) == $past(fault_plane))
    else $error("fault bit lost");
  a_latch_gated: assert property (!state_fault_latch_en |=> $stable(fault_plane))
    else $error("latched while off");
  a_latch_sense: assert property (state_fault_latch_en && sense_ov[0] |=> fault_plane[0])
    else $error("fault not latched");
  a_warn_aux: assert property (lim_aux != 3'h0 |=> warning)
    else $error("warning missed");
  a_read_dig: assert property (reg_rd && reg_addr == 8'hE8 |=> reg_rdata_r == {3'h0, $past(dual_logic)})
    else $error("logic state wrong");
  a_unmapped_zero: assert property (reg_rd && (reg_addr < 8'hE0 || reg_addr > 8'hE8) |=> reg_rdata_r == 8'h00)
    else $error("unmapped not zero");
  a_hit_decode: assert property (reg_hit == ((reg_rd || reg_wr) && reg_addr >= 8'hE0 && reg_addr <= 8'hE8))
    else $error("hit wrong");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata_r))
    else $error("data moved");
endmodule // sfsp_chk
bind sfsp_status_plane sfsp_chk u_chk (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_rdata_r(reg_rdata_r), .reg_hit(reg_hit),
  .state_fault_latch_en(state_fault_latch_en), .warning(warning), .sense_ov(sense_ov),
  .dual_logic(dual_logic), .lim_aux(lim_aux), .fault_plane(fault_plane));
`default_nettype wire

/* sfsp_host.sv */
// sfsp_host.sv: host model reading the plane.
// assumes read data lands on the strobe edge.
`timescale 1ns/1ps
`default_nettype none
module sfsp_host (
  input wire logic ref_clk,
  input wire logic [7:0] reg_rdata_r,
  output var logic [7:0] reg_addr,
  output var logic reg_rd,
  output var logic reg_wr,
  output var logic [7:0] reg_wdata
);
  // idle port at time zero
  initial begin
    {reg_addr, reg_rd, reg_wr, reg_wdata} = '0;
  end
  // one strobe; data changes so stale values show
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] dw, output logic [7:0] d);
    @(posedge ref_clk);
    #1 {reg_addr, reg_rd, reg_wr, reg_wdata} = {a, !w, w, dw};
    @(posedge ref_clk);
    #1 {reg_rd, reg_wr, reg_wdata} = {2'h0, ~dw};
    d = reg_rdata_r;
  endtask
endmodule // sfsp_host
`default_nettype wire

/* tb_top.sv */
// tb_top.sv: register test of the status plane.
// assumes host model and checker compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk, rst_b, len, hov, huv, lhi, warn, rd, wr;
  logic [4:0] dig, sov, suv, dov, duv, dlog, ldual, dde;
  logic [3:0] snov, snuv, lsen;
  logic [2:0] laux;
  logic [7:0] ra, wd, rdat, d;
  logic [9:0] fp;
  int bad_count, samples_checked;
  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;
  sfsp_host i_host (.ref_clk(ref_clk), .reg_rdata_r(rdat), .reg_addr(ra), .reg_rd(rd), .reg_wr(wr),
    .reg_wdata(wd));
  sfsp_status_plane i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(ra), .reg_rd(rd), .reg_wr(wr),
    .reg_wdata(wd), .reg_rdata_r(rdat), .reg_hit(), .state_fault_latch_en(len), .warning(warn),
    .dual_is_digital(dig), .sense_ov(snov), .sense_uv(snuv), .high_ov(hov), .high_uv(huv),
    .sec_ov(sov), .sec_uv(suv), .dual_ov(dov), .dual_uv(duv), .dual_logic(dlog), .lim_sense(lsen),
    .lim_high(lhi), .lim_dual(ldual), .lim_aux(laux), .dual_deasserted(dde), .fault_plane(fp));
  task automatic chk(input logic [7:0] g, e);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [7:0] a, e);
    i_host.xfer(a, 1'b0, 8'h00, d);
    chk(d, e);
  endtask
  task automatic finish_test;
    $display("checks %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // latch enable high for exactly one edge
  task automatic pulse;
    @(posedge ref_clk);
    #1 len = 1;
    @(posedge ref_clk);
    #1 len = 0;
  endtask
  initial begin
    {ref_clk, rst_b, len, hov, huv, lhi, dig, sov, suv, dov, duv, dlog, ldual, dde, snov, snuv, lsen, laux} = '0;
    bad_count = 0;
    samples_checked = 0;
    repeat (6) @(posedge ref_clk);
    #1 rst_b = 1;
    // detector mode, faults present, latching off
    {snov, hov, dov, duv, lsen, ldual, laux, sov} = {4'h1, 1'b1, 5'h05, 5'h10, 4'h2, 5'h09, 3'h5, 5'h1F};
    rc(8'hE0, 8'h00);
    rc(8'hE2, 8'hB1);
    rc(8'hE3, 8'h00);
    rc(8'hE5, 8'h02);
    rc(8'hE6, 8'h22);
    rc(8'hE7, 8'h15);
    chk({7'h00, warn}, 8'h01);
    pulse();
    {snov, hov, dov, duv, lsen, ldual, laux} = '0;
    rc(8'hE0, 8'hB3);
    rc(8'hE1, 8'h03);
    chk({7'h00, warn}, 8'h00);
    // digital mode: level captured, secondary detectors live
    {dig, dlog, sov, suv} = {5'h1F, 5'h16, 5'h0A, 5'h05};
    rc(8'hE2, 8'h40);
    rc(8'hE4, 8'hA0);
    rc(8'hE3, 8'h01);
    rc(8'hE8, 8'h16);
    chk({7'h00, warn}, 8'h01);
    pulse();
    dlog = 5'h00;
    rc(8'hE0, 8'hF3);
    rc(8'hE8, 8'h00);
    i_host.xfer(8'hE0, 1'b1, 8'hFF, d);
    rc(8'hE0, 8'hF3);
    rc(8'hE9, 8'h00);
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
